/* File: data_move_instr_exec.sv */
`timescale 1ns/1ps
module data_move_instr_exec
   import data_move_pkg::*;
#(
   parameter logic [7:0]  ACCESS_SPLIT = 8'h80,
   parameter logic [11:0] ACCUM_ADDR   = 12'hFFF
)
(
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   input  wire logic        en_i,
   input  wire logic        instr_valid_i,
   input  wire logic [15:0] instr_i,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic [1:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output mem_req_t         mem_req_o,
   output phase_t           phase_o,
   output logic [7:0]       accum_o,
   output logic [7:0]       bank_o,
   output logic             flag_neg_o,
   output logic             flag_zero_o,
   output logic [7:0]       reg_rdata_o,
   output logic             foreign_o,
   output logic             seq_err_o
);

   phase_t      phase_ff,  nxt_phase;
   op_t         op_ff,     nxt_op;
   logic        dest_ff,   nxt_dest;
   logic [11:0] addr_ff,   nxt_addr;
   logic [7:0]  lit_ff,    nxt_lit;
   logic [7:0]  data_ff,   nxt_data;
   logic [7:0]  accum_ff,  nxt_accum;
   logic [7:0]  bank_ff,   nxt_bank;
   logic        neg_ff,    nxt_neg;
   logic        zero_ff,   nxt_zero;
   mem_req_t    mem_ff,    nxt_mem;
   logic [7:0]  rdata_ff,  nxt_rdata;
   logic        foreign_ff, nxt_foreign;
   logic        seq_err_ff, nxt_seq_err;
   logic        addr_is_w;
   logic [7:0]  moved;

   // Bank forming from the access bit and bank select value
   function automatic logic [11:0] eff_addr(input logic use_bank, input logic [7:0] f,
                                             input logic [7:0] bank_sel);
      if (use_bank)
         eff_addr = {bank_sel[BANK_W-1:0], f}; // RULE2 RULE3
      else if (f < ACCESS_SPLIT)
         eff_addr = {ACC_LO_BANK, f}; // RULE2
      else
         eff_addr = {ACC_HI_BANK, f}; // RULE2
   endfunction

   // The accumulator lives in data space; it is served here, not by memory
   function automatic logic is_accum(input logic [11:0] a);
      is_accum = (a == ACCUM_ADDR);
   endfunction

   assign addr_is_w = is_accum(addr_ff);
   assign moved     = addr_is_w ? accum_ff : mem_rdata_i; // RULE6

   always_comb
   begin
      nxt_phase   = phase_ff;
      nxt_op      = op_ff;
      nxt_dest    = dest_ff;
      nxt_addr    = addr_ff;
      nxt_lit     = lit_ff;
      nxt_data    = data_ff;
      nxt_accum   = accum_ff;
      nxt_bank    = bank_ff;
      nxt_neg     = neg_ff;
      nxt_zero    = zero_ff;
      nxt_mem     = mem_ff;
      nxt_mem.rd  = 1'b0;
      nxt_mem.wr  = 1'b0;
      nxt_rdata   = RST_BYTE;
      nxt_foreign = 1'b0;
      nxt_seq_err = 1'b0;
      if (en_i)
      begin
         // Software port first so a core update in the same cycle wins
         if (reg_wr_i)
         begin
            unique case (reg_addr_i)
               REG_ACCUM:  nxt_accum = reg_wdata_i;
               REG_BANK:   nxt_bank  = reg_wdata_i;
               REG_STATUS:
               begin
                  nxt_neg  = reg_wdata_i[ST_N];
                  nxt_zero = reg_wdata_i[ST_Z];
               end
               default:    nxt_accum = accum_ff;
            endcase
         end
         if (reg_rd_i)
         begin
            unique case (reg_addr_i)
               REG_ACCUM:  nxt_rdata = accum_ff;
               REG_BANK:   nxt_rdata = bank_ff;
               REG_STATUS:
               begin
                  nxt_rdata       = RST_BYTE;
                  nxt_rdata[ST_N] = neg_ff;
                  nxt_rdata[ST_Z] = zero_ff;
               end
               default:    nxt_rdata = RST_BYTE;
            endcase
         end
         unique case (phase_ff)
            Q1:
            begin
               nxt_phase = Q2;
               if (!instr_valid_i)
               begin
                  // A bubble keeps a pending second word waiting; its Q3 must not recapture the source
                  nxt_dest = 1'b0;
                  if (op_ff != OP_FFSRC)
                     nxt_op = OP_NONE;
               end
               else if (op_ff == OP_FFSRC)
               begin
                  if (instr_i[15:12] == FF2_PFX) // RULE4
                  begin
                     nxt_op   = OP_FFDST;
                     nxt_addr = instr_i[11:0]; // RULE5
                  end
                  else
                  begin
                     nxt_op      = OP_NONE;
                     nxt_seq_err = 1'b1;
                  end
               end
               else if (instr_i[15:10] == {FCOPY_PFX, FCOPY_SUB}) // RULE1
               begin
                  nxt_op   = OP_FCOPY;
                  nxt_dest = instr_i[D_BIT];
                  nxt_addr = eff_addr(instr_i[A_BIT], instr_i[7:0], bank_ff); // RULE2
               end
               else if (instr_i[15:12] == FF1_PFX) // RULE4
               begin
                  nxt_op   = OP_FFSRC;
                  nxt_dest = 1'b1; // Source read is live in this cycle
                  nxt_addr = instr_i[11:0]; // RULE5
               end
               else if (instr_i[15:8] == BANK_PFX) // RULE9
               begin
                  nxt_op  = OP_BANK;
                  nxt_lit = instr_i[7:0];
               end
               else if (instr_i[15:8] == ACCLD_PFX) // RULE11
               begin
                  nxt_op  = OP_ACCLD;
                  nxt_lit = instr_i[7:0];
               end
               else if (instr_i[15:9] == ASTORE_PFX) // RULE12
               begin
                  nxt_op   = OP_ASTORE;
                  nxt_addr = eff_addr(instr_i[A_BIT], instr_i[7:0], bank_ff); // RULE2
               end
               else
               begin
                  nxt_op      = OP_NONE;
                  nxt_foreign = 1'b1;
               end
               nxt_mem.addr = nxt_addr;
               // Source read in Q2; data comes back during Q3
               nxt_mem.rd   = instr_valid_i && (nxt_op == OP_FCOPY || nxt_op == OP_FFSRC)
                              && !is_accum(nxt_addr); // RULE8 RULE15
            end
            Q2:
               nxt_phase = Q3;
            Q3:
            begin
               nxt_phase = Q4;
               unique case (op_ff)
                  OP_FCOPY:
                  begin
                     nxt_data = moved;
                     nxt_neg  = moved[7]; // RULE14
                     nxt_zero = (moved == RST_BYTE); // RULE14
                     if (!dest_ff || addr_is_w)
                        nxt_accum = moved; // RULE1
                     else
                     begin
                        nxt_mem.wr    = 1'b1; // RULE1
                        nxt_mem.wdata = moved;
                     end
                  end
                  OP_FFSRC:
                     if (dest_ff)
                        nxt_data = moved; // RULE8
                  OP_FFDST:
                  begin
                     // Counter and stack-top targets are written like any other
                     if (addr_is_w)
                        nxt_accum = data_ff; // RULE6 RULE7
                     else
                     begin
                        nxt_mem.wr    = 1'b1; // RULE8
                        nxt_mem.wdata = data_ff;
                     end
                  end
                  OP_BANK:
                     nxt_bank = lit_ff; // RULE10
                  OP_ACCLD:
                     nxt_accum = lit_ff; // RULE11
                  OP_ASTORE:
                  begin
                     nxt_data = accum_ff;
                     if (!addr_is_w)
                     begin
                        nxt_mem.wr    = 1'b1; // RULE12 RULE13
                        nxt_mem.wdata = accum_ff;
                     end
                  end
                  OP_NONE:
                     nxt_data = data_ff;
               endcase
            end
            Q4:
               nxt_phase = Q1; // RULE15
         endcase
      end
      else
      begin
         nxt_mem     = mem_ff;
         nxt_rdata   = rdata_ff;
         nxt_foreign = foreign_ff;
         nxt_seq_err = seq_err_ff;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         phase_ff   <= Q1;
         op_ff      <= OP_NONE;
         dest_ff    <= 1'b0;
         addr_ff    <= '0;
         lit_ff     <= RST_BYTE;
         data_ff    <= RST_BYTE;
         accum_ff   <= RST_BYTE;
         bank_ff    <= RST_BYTE;
         neg_ff     <= 1'b0;
         zero_ff    <= 1'b0;
         mem_ff     <= '0;
         rdata_ff   <= RST_BYTE;
         foreign_ff <= 1'b0;
         seq_err_ff <= 1'b0;
      end
      else
      begin
         phase_ff   <= nxt_phase;
         op_ff      <= nxt_op;
         dest_ff    <= nxt_dest;
         addr_ff    <= nxt_addr;
         lit_ff     <= nxt_lit;
         data_ff    <= nxt_data;
         accum_ff   <= nxt_accum;
         bank_ff    <= nxt_bank;
         neg_ff     <= nxt_neg;
         zero_ff    <= nxt_zero;
         mem_ff     <= nxt_mem;
         rdata_ff   <= nxt_rdata;
         foreign_ff <= nxt_foreign;
         seq_err_ff <= nxt_seq_err;
      end
   end

   assign mem_req_o   = mem_ff;
   assign phase_o     = phase_ff;
   assign accum_o     = accum_ff;
   assign bank_o      = bank_ff;
   assign flag_neg_o  = neg_ff;
   assign flag_zero_o = zero_ff;
   assign reg_rdata_o = rdata_ff;
   assign foreign_o   = foreign_ff;
   assign seq_err_o   = seq_err_ff;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   property p_write_in_q4;
      mem_ff.wr |-> phase_ff == Q4;
   endproperty
   a_write_in_q4: assert property (p_write_in_q4) else $error("write outside Q4"); // RULE15

   property p_read_in_q2;
      mem_ff.rd |-> phase_ff == Q2 && (op_ff == OP_FCOPY || op_ff == OP_FFSRC);
   endproperty
   a_read_in_q2: assert property (p_read_in_q2) else $error("read outside Q2"); // RULE8
   property p_bank_load;
      $changed(bank_ff) && !$past(reg_wr_i) |-> phase_ff == Q4 && op_ff == OP_BANK && bank_ff == lit_ff;
   endproperty
   a_bank_load: assert property (p_bank_load) else $error("bank changed wrongly"); // RULE10
   property p_accld;
      phase_ff == Q4 && op_ff == OP_ACCLD && !$past(reg_wr_i) |-> accum_ff == lit_ff;
   endproperty
   a_accld: assert property (p_accld) else $error("literal not in accumulator"); // RULE11
   property p_flags_only_fcopy;
      $changed({neg_ff, zero_ff}) && !$past(reg_wr_i) |-> op_ff == OP_FCOPY && phase_ff == Q4;
   endproperty
   a_flags_only_fcopy: assert property (p_flags_only_fcopy) else $error("flags changed"); // RULE13

   property p_fcopy_flags;
      phase_ff == Q4 && $past(phase_ff) == Q3 && op_ff == OP_FCOPY
         |-> neg_ff == data_ff[7] && zero_ff == (data_ff == RST_BYTE);
   endproperty
   a_fcopy_flags: assert property (p_fcopy_flags) else $error("bad copy flags"); // RULE14

   property p_fcopy_dest;
      phase_ff == Q4 && op_ff == OP_FCOPY && !addr_is_w |-> mem_ff.wr == dest_ff;
   endproperty
   a_fcopy_dest: assert property (p_fcopy_dest) else $error("copy destination wrong"); // RULE1

   property p_ff_write;
      phase_ff == Q4 && op_ff == OP_FFDST && !addr_is_w
         |-> mem_ff.wr && mem_ff.wdata == data_ff && mem_ff.addr == addr_ff;
   endproperty
   a_ff_write: assert property (p_ff_write) else $error("copy write wrong"); // RULE8

   property p_store;
      phase_ff == Q4 && op_ff == OP_ASTORE && !addr_is_w
         |-> mem_ff.wr && mem_ff.addr == addr_ff && mem_ff.wdata == data_ff;
   endproperty
   a_store: assert property (p_store) else $error("store wrong"); // RULE12

   c_fcopy:  cover property (phase_ff == Q4 && op_ff == OP_FCOPY && dest_ff);
   c_ffdst:  cover property (phase_ff == Q4 && op_ff == OP_FFDST);
   c_bank:   cover property (phase_ff == Q4 && op_ff == OP_BANK);
   c_store:  cover property (phase_ff == Q4 && op_ff == OP_ASTORE);

endmodule

/* File: data_move_pkg.sv */
// Operation
// RULE1 - File copy: d=0 to accumulator, d=1 back
// RULE2 - Access bit 0 access bank, 1 uses bank
// RULE3 - 8-bit operand reaches whole 256-byte bank
// RULE4 - Two-word copy: prefixes 1100 then 1111
// RULE5 - Copy addresses span 000h to FFFh
// RULE6 - Copy works with accumulator as either end
// RULE7 - Counter/stack-top destinations give undefined results
// RULE8 - Copy: two cycles, source read, late write
// RULE9 - Bank literal load decoded, one word, one cycle
// RULE10 - Bank load writes literal in Q4, no flags
// RULE11 - Accumulator literal load, one cycle, no flags
// RULE12 - Accumulator store writes register in Q4
// RULE13 - Only file copy touches negative and zero
// RULE14 - File copy sets negative and zero flags
// RULE15 - Single-word moves finish in one four-phase cycle
package data_move_pkg;

   localparam logic [3:0] FCOPY_PFX   = 4'h5;
   localparam logic [1:0] FCOPY_SUB   = 2'h0;
   localparam logic [3:0] FF1_PFX     = 4'hC;
   localparam logic [3:0] FF2_PFX     = 4'hF;
   localparam logic [7:0] BANK_PFX    = 8'h01;
   localparam logic [7:0] ACCLD_PFX   = 8'h0E;
   localparam logic [6:0] ASTORE_PFX  = 7'h37;
   localparam int         D_BIT       = 9;
   localparam int         A_BIT       = 8;
   localparam int         BANK_W      = 4;
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [7:0] RST_BYTE    = 8'h00;

   localparam logic [1:0] REG_ACCUM   = 2'h0;
   localparam logic [1:0] REG_BANK    = 2'h1;
   localparam logic [1:0] REG_STATUS  = 2'h2;
   localparam int         ST_Z        = 0;
   localparam int         ST_N        = 1;

   typedef enum logic [3:0] {
      Q1 = 4'h1,
      Q2 = 4'h2,
      Q3 = 4'h4,
      Q4 = 4'h8
   } phase_t;

   typedef enum logic [6:0] {
      OP_NONE   = 7'h01,
      OP_FCOPY  = 7'h02,
      OP_FFSRC  = 7'h04,
      OP_FFDST  = 7'h08,
      OP_BANK   = 7'h10,
      OP_ACCLD  = 7'h20,
      OP_ASTORE = 7'h40
   } op_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } mem_req_t;

endpackage

/* File: data_move_instr_exec_tb.sv */
`timescale 1ns/1ps
module data_move_instr_exec_tb;
   import data_move_pkg::*;
   logic        clock_i;
   logic        arst_n_i;
   logic        en_i;
   logic        instr_valid_i;
   logic [15:0] instr_i;
   logic [7:0]  mem_rdata_i;
   logic [1:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   mem_req_t    mem_req_o;
   mem_req_t    q2_req;
   phase_t      phase_o;
   logic [7:0]  accum_o;
   logic [7:0]  bank_o;
   logic [7:0]  reg_rdata_o;
   logic        flag_neg_o;
   logic        flag_zero_o;
   logic        foreign_o;
   logic        seq_err_o;
   logic        q2_foreign;
   logic        q2_err;
   logic [7:0]  acc_exp;
   logic [1:0]  fl_exp;
   int          n_mismatch;
   int          comparisons;
   int          cycles;

   data_move_instr_exec #(.ACCESS_SPLIT(8'h80), .ACCUM_ADDR(12'hFFF)) i_dut
   (
      .clock_i       (clock_i),
      .arst_n_i      (arst_n_i),
      .en_i          (en_i),
      .instr_valid_i (instr_valid_i),
      .instr_i       (instr_i),
      .mem_rdata_i   (mem_rdata_i),
      .reg_addr_i    (reg_addr_i),
      .reg_wdata_i   (reg_wdata_i),
      .reg_wr_i      (reg_wr_i),
      .reg_rd_i      (reg_rd_i),
      .mem_req_o     (mem_req_o),
      .phase_o       (phase_o),
      .accum_o       (accum_o),
      .bank_o        (bank_o),
      .flag_neg_o    (flag_neg_o),
      .flag_zero_o   (flag_zero_o),
      .reg_rdata_o   (reg_rdata_o),
      .foreign_o     (foreign_o),
      .seq_err_o     (seq_err_o)
   );

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Well above the roughly 120 cycles the sequence needs
   always @(posedge clock_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic ck(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Word goes out on the edge entering Q1 so the next edge takes it; returns settled in Q4
   task automatic exec(input logic [15:0] word, input logic [7:0] rdata);
      do @(posedge clock_i); while (phase_o !== Q4);
      instr_i       <= word;
      instr_valid_i <= 1'b1;
      mem_rdata_i   <= rdata;
      @(posedge clock_i);
      instr_valid_i <= 1'b0;
      #1;
      q2_req     = mem_req_o;
      q2_foreign = foreign_o;
      q2_err     = seq_err_o;
      @(posedge clock_i);
      @(posedge clock_i);
      #1;
   endtask

   task automatic reg_write(input logic [1:0] addr, input logic [7:0] data);
      @(posedge clock_i);
      reg_addr_i  <= addr;
      reg_wdata_i <= data;
      reg_wr_i    <= 1'b1;
      @(posedge clock_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic reg_read(input logic [1:0] addr, input logic [7:0] exp);
      @(posedge clock_i);
      reg_addr_i <= addr;
      reg_rd_i   <= 1'b1;
      @(posedge clock_i);
      reg_rd_i   <= 1'b0;
      #1;
      ck(reg_rdata_o, exp, "register read data");
      @(posedge clock_i);
      #1;
      ck(reg_rdata_o, 8'h00, "read data after its cycle");
   endtask

   task automatic t_regs;
      phase_t ph;
      reg_write(2'h1, 8'h3C);
      reg_read(2'h1, 8'h3C);
      reg_write(2'h3, 8'hFF);
      reg_read(2'h3, 8'h00);
      reg_write(2'h0, 8'h81);
      reg_write(2'h2, 8'h03);
      reg_read(2'h2, 8'h03);
      acc_exp = 8'h81;
      fl_exp  = 2'h3;
      ck(accum_o, acc_exp, "accumulator written");
      // A frozen core must not advance its phase
      @(posedge clock_i);
      en_i <= 1'b0;
      @(posedge clock_i);
      #1;
      ph = phase_o;
      repeat (3) @(posedge clock_i);
      #1;
      ck(phase_o, ph, "phase while disabled");
      @(posedge clock_i);
      en_i <= 1'b1;
   endtask

   task automatic t_literal;
      exec(16'h0EA5, 8'h00);
      acc_exp = 8'hA5;
      ck(accum_o, acc_exp, "accumulator literal");
      ck({flag_neg_o, flag_zero_o}, fl_exp, "flags after accumulator literal");
      exec(16'h01C7, 8'h00);
      ck(q2_foreign, 1'b0, "bank literal decoded");
      ck(bank_o, 8'hC7, "bank literal");
      ck({flag_neg_o, flag_zero_o}, fl_exp, "flags after bank literal");
      exec(16'h0000, 8'h00);
      ck(q2_foreign, 1'b1, "other opcode flagged");
      ck(accum_o, acc_exp, "accumulator after other opcode");
   endtask

   task automatic t_fcopy;
      logic [15:0] words [5] = '{16'h5010, 16'h5090, 16'h51FF, 16'h5200, 16'h537F};
      logic [7:0]  vals [5]  = '{8'h80, 8'h00, 8'h7E, 8'h00, 8'h81};
      logic [11:0] ea;
      for (int i = 0; i < 5; i++)
      begin
         ea = words[i][8] ? {4'h7, words[i][7:0]}
            : (words[i][7:0] < 8'h80 ? {4'h0, words[i][7:0]} : {4'hF, words[i][7:0]});
         if (!words[i][9])
            acc_exp = vals[i];
         fl_exp = {vals[i][7], vals[i] == 8'h00};
         exec(words[i], vals[i]);
         ck(q2_req.rd, 1'b1, "copy read strobe");
         ck(q2_req.addr, ea, "copy address");
         ck(phase_o, Q4, "copy result phase");
         ck(mem_req_o.wr, words[i][9], "copy write select");
         ck(accum_o, acc_exp, "copy accumulator");
         ck(mem_req_o.addr, ea, "copy write address");
         if (words[i][9])
            ck(mem_req_o.wdata, vals[i], "copy write data");
         ck({flag_neg_o, flag_zero_o}, fl_exp, "copy flags");
      end
   endtask

   task automatic t_store;
      logic [15:0] words [2] = '{16'h6E42, 16'h6FA0};
      logic [11:0] eas [2]   = '{12'h042, 12'h7A0};
      for (int i = 0; i < 2; i++)
      begin
         exec(words[i], 8'h5A);
         ck(mem_req_o.wr, 1'b1, "store write strobe");
         ck(mem_req_o.addr, eas[i], "store address");
         ck(mem_req_o.wdata, acc_exp, "store data");
         ck({flag_neg_o, flag_zero_o}, fl_exp, "store flags");
      end
   endtask

   task automatic t_ffcopy;
      logic [11:0] srcs [3] = '{12'h000, 12'hFFF, 12'h800};
      logic [11:0] dsts [3] = '{12'hFFE, 12'h000, 12'hFFF};
      logic [7:0]  vals [3] = '{8'h5C, 8'h00, 8'h3D};
      logic [7:0]  v;
      for (int i = 0; i < 3; i++)
      begin
         v = (srcs[i] == 12'hFFF) ? acc_exp : vals[i];
         exec({4'hC, srcs[i]}, vals[i]);
         ck(q2_req.rd, srcs[i] != 12'hFFF, "first word read");
         if (srcs[i] != 12'hFFF)
            ck(q2_req.addr, srcs[i], "source address");
         ck(mem_req_o.wr, 1'b0, "no write in first cycle");
         // One idle instruction cycle with a different bus value before the second word
         @(posedge clock_i);
         mem_rdata_i <= 8'hEE;
         repeat (3) @(posedge clock_i);
         // Read data changes on purpose: the source must already be held
         exec({4'hF, dsts[i]}, 8'hEE);
         ck(q2_req.rd, 1'b0, "no second read");
         ck(q2_err, 1'b0, "pair accepted");
         if (dsts[i] == 12'hFFF)
         begin
            acc_exp = v;
            ck(accum_o, v, "copy into accumulator");
         end
         else
         begin
            ck(mem_req_o.wr, 1'b1, "destination write");
            ck(mem_req_o.addr, dsts[i], "destination address");
            ck(mem_req_o.wdata, v, "moved value");
         end
         ck({flag_neg_o, flag_zero_o}, fl_exp, "two-word flags");
      end
   endtask

   task automatic t_seqerr;
      exec(16'hC010, 8'h11);
      exec(16'h0E22, 8'h00);
      ck(q2_err, 1'b1, "broken pair flagged");
      ck(mem_req_o.wr, 1'b0, "broken pair writes nothing");
   endtask

   initial
   begin
      arst_n_i      = 1'b0;
      en_i          = 1'b1;
      instr_valid_i = 1'b0;
      instr_i       = 16'h0000;
      mem_rdata_i   = 8'h00;
      reg_addr_i    = 2'h0;
      reg_wdata_i   = 8'h00;
      reg_wr_i      = 1'b0;
      reg_rd_i      = 1'b0;
      repeat (6) @(posedge clock_i);
      #1;
      ck(phase_o, Q1, "phase in reset");
      ck({accum_o, bank_o, flag_neg_o, flag_zero_o}, 18'h0, "state in reset");
      @(posedge clock_i);
      arst_n_i <= 1'b1;
      t_regs();
      t_literal();
      t_fcopy();
      t_store();
      t_ffcopy();
      t_seqerr();
      finish_test();
   end
endmodule
